// *** bench/tb_uds_top.sv ***
// Self-checking bench for the up/down speed setpoint block.
// Assumes a short CYC_PER_MS so ramps of a few ms end in few cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_uds_top;
  import uds_pkg::*;
  localparam int CPM = 2;
  logic        clk, reset_n, wr, rd, send, nv_load, nv_wr_q, pzd2_valid;
  logic        raise_pin, lower_pin, motor_on_pin, manual_auto_pin;
  logic        limit_invert_pin, accept_preset_pin;
  logic        rd_q = 1'b0;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata_q, word_in, pzd2_word, nv_data, nv_wdata_q;
  logic [15:0] ramped_output_q, main_setpoint_q, additional_setpoint_q;
  logic [15:0] p, v, e_nv;
  logic [31:0] seed;
  int          num_errors, checks;
  logic [15:0] rq[$];
  logic [15:0] nq[$];

  uds_top #(.CYC_PER_MS(CPM)) u_uds_top (.clk, .reset_n, .addr, .wdata,
    .wr, .rd, .rdata_q, .raise_pin, .lower_pin, .motor_on_pin,
    .manual_auto_pin, .limit_invert_pin, .accept_preset_pin, .pzd2_word,
    .pzd2_valid, .nv_data, .nv_load, .nv_wdata_q, .nv_wr_q,
    .ramped_output_q, .main_setpoint_q, .additional_setpoint_q);
  uds_fbus_model u_uds_fbus_model (.clk, .reset_n, .send, .word_in,
    .pzd2_word, .pzd2_valid);

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] pick(input int w);
    case (w)
      0: return ramped_output_q;
      1: return main_setpoint_q;
      default: return additional_setpoint_q;
    endcase
  endfunction

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // Strobe tasks leave a gap cycle so no strobe is assigned twice at once
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    rq.push_back(e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
  endtask

  // Polls on the falling edge, where outputs have settled
  task automatic expect_out(input int w, input logic [15:0] e);
    for (int i = 0; i < 400 && pick(w) !== e; i++) @(negedge clk);
    chk("setpoint out", e, pick(w));
    @(posedge clk);
  endtask

  task automatic pulse_preset(input logic [15:0] d);
    wreg(UDS_A_PRESET, d);
    accept_preset_pin <= 1'b1;
    expect_out(0, d);
    accept_preset_pin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Read data and store writes are matched against the oldest note
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q && rq.size() > 0) chk("read data", rq.pop_front(), rdata_q);
    if (nv_wr_q) begin
      e_nv = (nq.size() > 0) ? nq.pop_front() : 16'hxxxx;
      chk("nv data", e_nv, nv_wdata_q);
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    {reset_n, wr, rd, send, nv_load, raise_pin, lower_pin} = '0;
    {motor_on_pin, manual_auto_pin, limit_invert_pin} = '0;
    accept_preset_pin = 1'b0;
    {addr, wdata, word_in, nv_data} = '0;
    seed = 32'hc17c_0f40;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rreg(UDS_A_CFG, 16'h0006);
    rreg(UDS_A_START, 16'h0000);
    rreg(UDS_A_RUP, 16'h2710);
    rreg(UDS_A_RDN, 16'h2710);
    rreg(UDS_A_MAX, 16'h0000);
    rreg(UDS_A_MIN, 16'h0000);
    rreg(4'hF, 16'h0000);
    $display("reset values done");
    wreg(UDS_A_MAX, 16'h03E8);
    wreg(UDS_A_MIN, 16'hFED4);
    seed = lfsr(seed);
    p = {7'h00, seed[8:0]};
    pulse_preset(p);
    rreg(UDS_A_OUT, p);
    $display("preset done");
    seed = lfsr(seed);
    wreg(UDS_A_SEL, 16'h0005);
    send    <= 1'b1;
    word_in <= seed[31:16];
    @(posedge clk);
    send <= 1'b0;
    expect_out(1, seed[31:16]);
    expect_out(2, seed[31:16]);
    wreg(UDS_A_SEL, 16'h0008);
    expect_out(1, p);
    expect_out(2, 16'h0000);
    $display("setpoint select done");
    // Automatic mode with ramping off jumps straight to the limit
    wreg(UDS_A_CFG, 16'h0000);
    manual_auto_pin <= 1'b1;
    motor_on_pin    <= 1'b1;
    expect_out(0, 16'h0000);
    raise_pin <= 1'b1;
    expect_out(0, 16'h03E8);
    raise_pin        <= 1'b0;
    limit_invert_pin <= 1'b1;
    lower_pin        <= 1'b1;
    expect_out(0, 16'hFC18);
    lower_pin <= 1'b0;
    raise_pin <= 1'b1;
    expect_out(0, 16'h012C);
    raise_pin        <= 1'b0;
    limit_invert_pin <= 1'b0;
    $display("auto jump done");
    // Manual mode ramps even with the ramp bit clear
    wreg(UDS_A_MAX, 16'h0014);
    wreg(UDS_A_RUP, 16'h0001);
    wreg(UDS_A_RDN, 16'h0001);
    pulse_preset(16'h0000);
    manual_auto_pin <= 1'b0;
    raise_pin       <= 1'b1;
    repeat (8) @(posedge clk);
    chk("ramping", 16'h0001, {15'h0000, $signed(ramped_output_q) < 20});
    lower_pin <= 1'b1;
    repeat (8) @(posedge clk);
    v = ramped_output_q;
    repeat (10) @(posedge clk);
    chk("both held", v, ramped_output_q);
    lower_pin <= 1'b0;
    expect_out(0, 16'h0014);
    raise_pin <= 1'b0;
    lower_pin <= 1'b1;
    expect_out(0, 16'hFED4);
    lower_pin    <= 1'b0;
    motor_on_pin <= 1'b0;
    repeat (8) @(posedge clk);
    raise_pin <= 1'b1;
    repeat (12) @(posedge clk);
    chk("frozen off", 16'hFED4, ramped_output_q);
    // Bit 4 lets the ramp run on with the motor off
    wreg(UDS_A_CFG, 16'h0010);
    expect_out(0, 16'h0014);
    raise_pin <= 1'b0;
    // Rounding halves the first steps: 7 steps in 64 cycles, not 14
    wreg(UDS_A_CFG, 16'h0014);
    wreg(UDS_A_RDN, 16'h0028);
    lower_pin <= 1'b1;
    repeat (64) @(posedge clk);
    chk("rounding", 16'h0001, {15'h0000, $signed(ramped_output_q) > 9});
    lower_pin <= 1'b0;
    $display("ramp done");
    // Storage to the non-volatile port and restore at switch-on
    // Switch-on restores the store, still zero, so preset after it
    wreg(UDS_A_CFG, 16'h0009);
    motor_on_pin <= 1'b1;
    expect_out(0, 16'h0000);
    pulse_preset(16'h0011);
    nq.push_back(16'h0011);
    motor_on_pin <= 1'b0;
    repeat (8) @(posedge clk);
    rreg(UDS_A_STORE, 16'h0011);
    pulse_preset(16'h0005);
    motor_on_pin <= 1'b1;
    expect_out(0, 16'h0011);
    nq.push_back(16'h0011);
    motor_on_pin <= 1'b0;
    repeat (8) @(posedge clk);
    nv_data <= 16'h0077;
    nv_load <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
    @(posedge clk);
    rreg(UDS_A_STORE, 16'h0077);
    motor_on_pin <= 1'b1;
    // The restored value is held inside the maximum of 0x14
    expect_out(0, 16'h0014);
    $display("storage done");
    wreg(UDS_A_CFG, 16'h0000);
    wreg(UDS_A_START, 16'h0003);
    motor_on_pin <= 1'b0;
    repeat (8) @(posedge clk);
    motor_on_pin <= 1'b1;
    expect_out(0, 16'h0003);
    chk("store writes", 16'h0000, 16'(nq.size()));
    $display("start value done");
    complete_run();
  end
endmodule // tb_uds_top
`default_nettype wire

// *** bench/uds_fbus_model.sv ***
// Fieldbus partner: hands word two to the block with a one-cycle valid.
// Assumes the bench raises send for one cycle beside the word to send.
`timescale 1ns/1ps
`default_nettype none
module uds_fbus_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        send,
  input  wire logic [15:0] word_in,
  output logic      [15:0] pzd2_word,
  output logic             pzd2_valid
);
  // setpoint in word two
  // Between transfers the word toggles, so a stale value never looks valid
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pzd2_valid <= 1'b0;
      pzd2_word  <= 16'h0000;
    end else begin
      pzd2_valid <= send;
      pzd2_word  <= send ? word_in : ~pzd2_word;
    end
  end
endmodule // uds_fbus_model
`default_nettype wire

// *** design/uds_pkg.sv ***
// Constants shared by the up/down speed setpoint block.
// Assumes a 125 MHz system clock and signed 16-bit rpm values.
package uds_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] UDS_A_CFG    = 4'h0;
  localparam logic [3:0] UDS_A_START  = 4'h1;
  localparam logic [3:0] UDS_A_RUP    = 4'h2;
  localparam logic [3:0] UDS_A_RDN    = 4'h3;
  localparam logic [3:0] UDS_A_MAX    = 4'h4;
  localparam logic [3:0] UDS_A_MIN    = 4'h5;
  localparam logic [3:0] UDS_A_PRESET = 4'h6;
  localparam logic [3:0] UDS_A_SEL    = 4'h7;
  localparam logic [3:0] UDS_A_OUT    = 4'h8;
  localparam logic [3:0] UDS_A_PZD2   = 4'h9;
  localparam logic [3:0] UDS_A_STORE  = 4'hA;
  // Configuration field
  localparam int         UDS_CFG_W     = 5;
  localparam logic [4:0] UDS_CFG_RST   = 5'h06;
  localparam int         UDS_B_STORE   = 0;
  localparam int         UDS_B_RAMP    = 1;
  localparam int         UDS_B_ROUND   = 2;
  localparam int         UDS_B_NV      = 3;
  localparam int         UDS_B_ALWAYS  = 4;
  // Setpoint selector codes (2 bits each, main in [1:0], extra in [3:2])
  localparam logic [1:0] UDS_SEL_POT   = 2'h0;
  localparam logic [1:0] UDS_SEL_PZD2  = 2'h1;
  localparam logic [1:0] UDS_SEL_ZERO  = 2'h2;
  localparam logic [3:0] UDS_SEL_RST   = 4'h0;
  // Speeds and times
  localparam logic [15:0] UDS_SPEED_RST = 16'h0000;
  localparam int          UDS_RAMP_S    = 10;
  localparam logic [15:0] UDS_RAMP_RST  = 16'(UDS_RAMP_S * 1000);
  localparam int          UDS_CLK_HZ    = 125_000_000;
  localparam int          UDS_CYC_MS    = UDS_CLK_HZ / 1000;
  localparam logic [3:0]  UDS_ROUND_N   = 4'hF;
  localparam int          UDS_NPIN      = 6;
endpackage

// *** design/uds_top.sv ***
// Up/down speed setpoint with ramp, limits, storage and setpoint select.
// Assumes command pins come from outside the clock domain; the fieldbus
// word, register port and non-volatile store run on clk.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module uds_top
  import uds_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = UDS_CYC_MS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata_q,
  input  wire logic        raise_pin,
  input  wire logic        lower_pin,
  input  wire logic        motor_on_pin,
  input  wire logic        manual_auto_pin,
  input  wire logic        limit_invert_pin,
  input  wire logic        accept_preset_pin,
  input  wire logic [15:0] pzd2_word,
  input  wire logic        pzd2_valid,
  input  wire logic [15:0] nv_data,
  input  wire logic        nv_load,
  output logic      [15:0] nv_wdata_q,
  output logic             nv_wr_q,
  output logic      [15:0] ramped_output_q,
  output logic      [15:0] main_setpoint_q,
  output logic      [15:0] additional_setpoint_q
);

  // Elaboration check: a zero count would turn every ramp into a jump
  if (CYC_PER_MS == 0) begin : g_bad_rate
    $error("CYC_PER_MS must be nonzero");
  end

  // Pin synchronisers: three stages, accept once stages two and three agree
  logic [UDS_NPIN-1:0] pin_raw;
  logic [UDS_NPIN-1:0] pin_q;
  assign pin_raw = {accept_preset_pin, limit_invert_pin, manual_auto_pin,
                    motor_on_pin, lower_pin, raise_pin};

  genvar gi;
  generate
    for (gi = 0; gi < UDS_NPIN; gi++) begin : g_sync
      // Local stages, so each register has exactly one writing process
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic flt_q;
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          flt_q <= 1'b0;
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) flt_q <= s3_q;
        end
      end
      assign pin_q[gi] = flt_q;
    end
  endgenerate

  logic raise;
  logic lower;
  logic motor_on;
  logic auto_mode;
  logic invert;
  logic accept;
  assign raise     = pin_q[0];
  assign lower     = pin_q[1];
  assign motor_on  = pin_q[2];
  assign auto_mode = pin_q[3];
  assign invert    = pin_q[4];
  assign accept    = pin_q[5];

  // Previous levels for edge detection on filtered signals
  logic motor_prev_q;
  logic accept_prev_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      motor_prev_q  <= 1'b0;
      accept_prev_q <= 1'b0;
    end else begin
      motor_prev_q  <= motor_on;
      accept_prev_q <= accept;
    end
  end

  logic on_rise;
  logic off_fall;
  logic preset_rise;
  assign on_rise     = motor_on & ~motor_prev_q;
  assign off_fall    = ~motor_on & motor_prev_q;
  // only the 0 to 1 change counts
  assign preset_rise = accept & ~accept_prev_q;

  // Software registers
  logic [4:0]  cfg_q;
  logic [15:0] start_q;
  logic [15:0] rup_q;
  logic [15:0] rdn_q;
  logic [15:0] max_q;
  logic [15:0] min_q;
  logic [15:0] preset_q;
  logic [3:0]  sel_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_q    <= UDS_CFG_RST;
      start_q  <= UDS_SPEED_RST;
      rup_q    <= UDS_RAMP_RST;
      rdn_q    <= UDS_RAMP_RST;
      max_q    <= UDS_SPEED_RST;
      min_q    <= UDS_SPEED_RST;
      preset_q <= UDS_SPEED_RST;
      sel_q    <= UDS_SEL_RST;
    end else if (wr) begin
      case (addr)
        UDS_A_CFG:    cfg_q    <= wdata[UDS_CFG_W-1:0];
        UDS_A_START:  start_q  <= wdata;
        UDS_A_RUP:    rup_q    <= wdata;
        UDS_A_RDN:    rdn_q    <= wdata;
        UDS_A_MAX:    max_q    <= wdata;
        UDS_A_MIN:    min_q    <= wdata;
        UDS_A_PRESET: preset_q <= wdata;
        UDS_A_SEL:    sel_q    <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // Latest fieldbus word two, held between telegrams
  logic [15:0] pzd2_q;
  always_ff @(posedge clk) begin
    if (!reset_n) pzd2_q <= UDS_SPEED_RST;
    else if (pzd2_valid) pzd2_q <= pzd2_word;
  end

  // inversion swaps and negates the bounds
  logic signed [16:0] hi;
  logic signed [16:0] lo;
  always_comb begin
    if (invert) begin
      hi = -17'(signed'(min_q));
      lo = -17'(signed'(max_q));
    end else begin
      hi = 17'(signed'(max_q));
      lo = 17'(signed'(min_q));
    end
  end

  // clamp a value into the bounds; hi wins if they cross
  function automatic logic [15:0] clampv(input logic [15:0] v,
                                         input logic signed [16:0] h,
                                         input logic signed [16:0] l);
    logic signed [16:0] s;
    logic signed [16:0] r;
    s = 17'(signed'(v));
    r = s;
    if (r < l) r = l;
    if (r > h) r = h;
    if (r > 17'sd32767) r = 17'sd32767;
    if (r < -17'sd32768) r = -17'sd32768;
    return r[15:0];
  endfunction

  logic [15:0] out_q;
  logic [15:0] stored_q;
  logic [15:0] hi_c;
  logic [15:0] lo_c;
  logic [15:0] start_c;
  logic [15:0] preset_c;
  logic [15:0] restore_c;
  assign hi_c     = clampv(hi[15:0], hi, lo);
  assign lo_c     = clampv(lo[15:0], 17'sd32767, lo);
  assign start_c  = clampv(start_q, hi, lo);
  assign preset_c = clampv(preset_q, hi, lo);
  assign restore_c = clampv(stored_q, hi, lo);

  // Command decode; both commands at once hold the output
  logic up_cmd;
  logic dn_cmd;
  logic moving;
  logic run;
  logic ramp_on;
  assign up_cmd  = raise & ~lower;
  assign dn_cmd  = lower & ~raise;
  assign moving  = up_cmd | dn_cmd;
  // keep computing when off if bit 4 set
  assign run     = motor_on | cfg_q[UDS_B_ALWAYS];
  // ramp always in manual, bit 1 in automatic
  assign ramp_on = ~auto_mode | cfg_q[UDS_B_RAMP];

  logic [15:0] target;
  assign target = up_cmd ? hi_c : lo_c;

  // cycles for one full excursion of the maximum speed
  logic [39:0] t_cyc;
  logic [15:0] rate;
  logic [39:0] inc;
  logic [3:0]  round_q;
  logic [39:0] acc_q;
  logic [39:0] acc_sum;
  logic        step;
  logic        direct;
  logic        at_tgt;
  assign t_cyc = (up_cmd ? 40'(rup_q) : 40'(rdn_q)) * 40'(CYC_PER_MS);
  assign rate  = max_q[15] ? 16'(-max_q) : max_q;
  // half rate for the first steps of a move
  always_comb begin
    inc = (rate == 16'h0000) ? 40'h0_0000_0001 : 40'(rate);
    if (cfg_q[UDS_B_ROUND] && round_q != UDS_ROUND_N) begin
      inc = (inc > 40'h0_0000_0001) ? (inc >> 1) : inc;
    end
  end
  assign acc_sum = acc_q + inc;
  assign direct  = ~ramp_on | (t_cyc == 40'h0_0000_0000);
  assign at_tgt  = (out_q == target);
  assign step    = run & moving & ~direct & ~at_tgt & (acc_sum >= t_cyc);

  // Fractional accumulator; one unit of speed per overflow
  always_ff @(posedge clk) begin
    if (!reset_n) acc_q <= 40'h0_0000_0000;
    else if (!(run & moving) || direct || at_tgt) acc_q <= 40'h0_0000_0000;
    else if (step) acc_q <= acc_sum - t_cyc;
    else acc_q <= acc_sum;
  end

  // Rounding counter restarts whenever the command drops
  always_ff @(posedge clk) begin
    if (!reset_n) round_q <= 4'h0;
    else if (!moving) round_q <= 4'h0;
    else if (step && round_q != UDS_ROUND_N) round_q <= round_q + 4'h1;
  end

  // Output value: preset first, then switch-on load, then ramp
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_q <= UDS_SPEED_RST;
    end else if (preset_rise) begin
      out_q <= preset_c;
    end else if (on_rise) begin
      out_q <= cfg_q[UDS_B_STORE] ? restore_c : start_c;
    end else if (run && moving) begin
      if (direct) out_q <= target;
      else if (step && $signed(target) > $signed(out_q))
        out_q <= out_q + 16'h0001;
      else if (step) out_q <= out_q - 16'h0001;
    end
  end

  // capture at switch-off, optional non-volatile copy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stored_q   <= UDS_SPEED_RST;
      nv_wr_q    <= 1'b0;
      nv_wdata_q <= UDS_SPEED_RST;
    end else begin
      nv_wr_q <= 1'b0;
      if (nv_load) begin
        stored_q <= nv_data;
      end else if (off_fall && cfg_q[UDS_B_STORE]) begin
        stored_q   <= out_q;
        nv_wr_q    <= cfg_q[UDS_B_NV];
        nv_wdata_q <= out_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ramped_output_q       <= UDS_SPEED_RST;
      main_setpoint_q       <= UDS_SPEED_RST;
      additional_setpoint_q <= UDS_SPEED_RST;
    end else begin
      ramped_output_q <= out_q;
      case (sel_q[1:0])
        UDS_SEL_POT:  main_setpoint_q <= out_q;
        UDS_SEL_PZD2: main_setpoint_q <= pzd2_q;
        default:      main_setpoint_q <= UDS_SPEED_RST;
      endcase
      case (sel_q[3:2])
        UDS_SEL_POT:  additional_setpoint_q <= out_q;
        UDS_SEL_PZD2: additional_setpoint_q <= pzd2_q;
        default:      additional_setpoint_q <= UDS_SPEED_RST;
      endcase
    end
  end

  // Read data valid the cycle after rd only; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!reset_n) rdata_q <= 16'h0000;
    else if (!rd) rdata_q <= 16'h0000;
    else begin
      case (addr)
        UDS_A_CFG:    rdata_q <= {11'h000, cfg_q};
        UDS_A_START:  rdata_q <= start_q;
        UDS_A_RUP:    rdata_q <= rup_q;
        UDS_A_RDN:    rdata_q <= rdn_q;
        UDS_A_MAX:    rdata_q <= max_q;
        UDS_A_MIN:    rdata_q <= min_q;
        UDS_A_PRESET: rdata_q <= preset_q;
        UDS_A_SEL:    rdata_q <= {12'h000, sel_q};
        UDS_A_OUT:    rdata_q <= out_q;
        UDS_A_PZD2:   rdata_q <= pzd2_q;
        UDS_A_STORE:  rdata_q <= stored_q;
        default:      rdata_q <= 16'h0000;
      endcase
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_quiet;
    !preset_rise && !on_rise;
  endsequence
  sequence s_switch_on;
    on_rise && !preset_rise;
  endsequence

  a_cfg_reset: assert property (
    $rose(reset_n) |-> cfg_q == UDS_CFG_RST)
    else $error("config not 00110 after reset");
  a_start_load: assert property (
    s_switch_on and !cfg_q[UDS_B_STORE] |=> out_q == $past(start_c))
    else $error("start value not loaded at switch-on");
  a_store_back: assert property (
    s_switch_on and cfg_q[UDS_B_STORE]
      |=> out_q == $past(restore_c))
    else $error("stored value not restored");
  a_preset_load: assert property (
    preset_rise |=> out_q == $past(preset_c))
    else $error("preset not taken on rising edge");
  a_jump_auto: assert property (
    s_quiet and run && moving && auto_mode && !cfg_q[UDS_B_RAMP]
      |=> out_q == $past(target))
    else $error("automatic mode without ramp did not jump");
  a_raise_up: assert property (
    s_quiet and run && up_cmd && !direct
      |=> $signed(out_q) >= $signed($past(out_q)))
    else $error("output fell while raising");
  a_both_hold: assert property (
    s_quiet and raise && lower |=> $stable(out_q))
    else $error("output moved with both commands");
  a_freeze_off: assert property (
    s_quiet and !motor_on && !cfg_q[UDS_B_ALWAYS] |=> $stable(out_q))
    else $error("output moved while motor off");
  a_main_pzd2: assert property (
    sel_q[1:0] == UDS_SEL_PZD2 |=> main_setpoint_q == $past(pzd2_q))
    else $error("main setpoint not from word two");
  a_extra_pzd2: assert property (
    sel_q[3:2] == UDS_SEL_PZD2 |=> additional_setpoint_q == $past(pzd2_q))
    else $error("additional setpoint not from word two");
  a_nv_write: assert property (
    off_fall && !nv_load && cfg_q[UDS_B_STORE] && cfg_q[UDS_B_NV]
      |=> nv_wr_q && nv_wdata_q == $past(out_q))
    else $error("non-volatile copy not written");

endmodule // uds_top
`default_nettype wire
